//--- serial_host_if.v
// spi and i2c host interface to the internal register map
`timescale 1ns/1ps
`include "host_if_consts.vh"

// Functional notes
// - frame select falling starts spi access
// - sample serial input on falling clock
// - short access discarded, no state change
// - three-wire uses first 24 bits only
// - select high: ignore clock, tristate output
// - frame: rw bit, 7-bit address, data
// - readback only with readout pin enabled
// - readback frame echoes rw, address, data
// - output launch edge chosen by select
// - daisy chain uses last 24 bits
// - four-wire non-multiple of 24 discarded
// - i2c target, 7-bit addresses only
// - same protocol at all bus speeds
// - general call 0x06 triggers soft reset
// - receiver acknowledges by holding data low
// - data falling with clock high: start
// - data rising with clock high: stop
// - acknowledge only matching target address or general call
// - direction bit picks transmitter, receiver acks
// - after stop, idle until matching start
// - first protocol used locks interface type
// - address is 1001 plus select pin bits
module serial_host_if (
    // clock and reset
    input  wire        clock,
    input  wire        reset,
    input  wire        clk_en,
    // spi pins
    input  wire        frame_sel_n,
    input  wire        spi_sclk,
    input  wire        spi_sdi,
    output wire        spi_sdo_o,
    output wire        spi_sdo_oe,
    // i2c pins, open drain
    input  wire        scl_i,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe,
    input  wire [2:0]  address_select_pin,
    // configuration from the register map
    input  wire        readout_pin_enable,
    input  wire        readout_edge_select,
    // register map port
    output wire        reg_wr,
    output wire        reg_rd,
    output wire [6:0]  reg_addr,
    output wire [15:0] reg_wdata,
    input  wire [15:0] reg_rdata,
    // device control
    output wire        soft_reset,
    output wire [1:0]  iface_type
);
    // ------------------------------------------------------------
    // i2c states
    // ------------------------------------------------------------
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_ADDR = 6'h02;
    localparam [5:0] S_AACK = 6'h04;
    localparam [5:0] S_RECV = 6'h08;
    localparam [5:0] S_RACK = 6'h10;
    localparam [5:0] S_SEND = 6'h20;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [7:0] pins_s;
    pin_sync #(.W(8)) u_sync (
        .clock     (clock),
        .reset     (reset),
        .clk_en    (clk_en),
        .pin_in    ({address_select_pin, sda_i, scl_i, spi_sdi,
                     spi_sclk, frame_sel_n}),
        .idle_val  (8'hff),
        .level_out (pins_s)
    );
    wire       cs_s   = pins_s[0];
    wire       sclk_s = pins_s[1];
    wire       sdi_s  = pins_s[2];
    wire       scl_s  = pins_s[3];
    wire       sda_s  = pins_s[4];
    wire [2:0] asel_s = pins_s[7:5];

    reg        cs_p_q;
    reg        sclk_p_q;
    reg        scl_p_q;
    reg        sda_p_q;
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            cs_p_q   <= 1'b1;
            sclk_p_q <= 1'b1;
            scl_p_q  <= 1'b1;
            sda_p_q  <= 1'b1;
        end else if (clk_en) begin
            cs_p_q   <= cs_s;
            sclk_p_q <= sclk_s;
            scl_p_q  <= scl_s;
            sda_p_q  <= sda_s;
        end
    end

    wire cs_fall   = cs_p_q & ~cs_s;
    wire cs_rise   = ~cs_p_q & cs_s;
    wire sclk_fall = sclk_p_q & ~sclk_s;
    wire sclk_rise = ~sclk_p_q & sclk_s;
    wire scl_rise  = ~scl_p_q & scl_s;
    wire scl_fall  = scl_p_q & ~scl_s;
    // clock stays high across both conditions
    wire i2c_start = scl_p_q & scl_s & sda_p_q & ~sda_s;
    wire i2c_stop  = scl_p_q & scl_s & ~sda_p_q & sda_s;

    // ------------------------------------------------------------
    // interface lock
    // ------------------------------------------------------------
    reg  [1:0] iface_q;
    wire       spi_allow = (iface_q != `IFACE_I2C);
    wire       i2c_allow = (iface_q != `IFACE_SPI);

    // ------------------------------------------------------------
    // spi receive
    // ------------------------------------------------------------
    reg  [23:0] in_q;
    reg  [23:0] first_q;
    reg  [4:0]  mod_q;
    reg         got_q;
    wire [23:0] in_next = {in_q[22:0], sdi_s};
    wire        spi_act = ~cs_s & spi_allow;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            in_q    <= 24'h000000;
            first_q <= 24'h000000;
            mod_q   <= 5'h00;
            got_q   <= 1'b0;
        end else if (clk_en) begin
            if (cs_fall) begin
                mod_q <= 5'h00;
                got_q <= 1'b0;
            end else if (spi_act & sclk_fall) begin
                in_q <= in_next;
                if (mod_q == `FRAME_LAST) begin
                    mod_q <= 5'h00;
                    got_q <= 1'b1;
                    if (!got_q)
                        first_q <= in_next;
                end else begin
                    mod_q <= mod_q + 5'h01;
                end
            end
        end
    end

    // short frames never reach got_q, so nothing is acted on
    wire spi_ok = got_q & (~readout_pin_enable | (mod_q == 5'h00));
    // four-wire keeps the newest 24 bits, three-wire the first
    wire [23:0] spi_word = readout_pin_enable ? in_q : first_q;
    wire spi_go   = cs_rise & spi_ok & spi_allow;
    wire spi_read = spi_word[`RW_BIT];

    // ------------------------------------------------------------
    // spi transmit; shifts input through for daisy chaining
    // ------------------------------------------------------------
    reg  [23:0] out_q;
    reg  [7:0]  hdr_q;
    reg         rd_src_spi_q;
    reg         rd_pend_q;
    // no rise launch before the first sample
    wire launch = spi_act & (readout_edge_select ? sclk_fall :
                  (sclk_rise & (got_q | (mod_q != 5'h00))));
    wire launch_bit = readout_edge_select ? sdi_s : in_q[0];

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            out_q <= 24'h000000;
        end else if (clk_en) begin
            if (rd_pend_q & rd_src_spi_q)
                out_q <= {hdr_q, reg_rdata};
            else if (cs_rise)
                out_q <= 24'h000000;
            else if (launch)
                out_q <= {out_q[22:0], launch_bit};
        end
    end

    assign spi_sdo_o  = out_q[23];
    assign spi_sdo_oe = ~cs_s & readout_pin_enable & spi_allow;

    // ------------------------------------------------------------
    // i2c target
    // ------------------------------------------------------------
    reg  [5:0] st_q;
    reg  [7:0] sh_q;
    reg  [3:0] bit_q;
    reg  [1:0] byte_q;
    reg        dir_q;
    reg        gcall_q;
    reg        drive_q;
    reg        ack_ok_q;
    reg  [6:0] cmd_q;
    reg  [7:0] msb_q;
    reg  [15:0] tx_q;
    reg        i2c_wr;
    reg        i2c_rd;
    reg        i2c_rst;
    wire [7:0] sh_next = {sh_q[6:0], sda_s};
    wire       addr_hit = (sh_q[7:1] == {`TARGET_ADDR_HI, asel_s});
    wire       gc_hit   = (sh_q == `GCALL_ADDR);

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            st_q     <= S_IDLE;
            sh_q     <= 8'h00;
            bit_q    <= 4'h0;
            byte_q   <= 2'h0;
            dir_q    <= 1'b0;
            gcall_q  <= 1'b0;
            drive_q  <= 1'b0;
            ack_ok_q <= 1'b0;
            cmd_q    <= 7'h00;
            msb_q    <= 8'h00;
            tx_q     <= 16'h0000;
            i2c_wr   <= 1'b0;
            i2c_rd   <= 1'b0;
            i2c_rst  <= 1'b0;
        end else if (clk_en) begin
            i2c_wr  <= 1'b0;
            i2c_rd  <= 1'b0;
            i2c_rst <= 1'b0;
            if (rd_pend_q & ~rd_src_spi_q)
                tx_q <= reg_rdata;
            if (!i2c_allow) begin
                st_q    <= S_IDLE;
                drive_q <= 1'b0;
            end else if (i2c_start) begin
                st_q    <= S_ADDR;
                bit_q   <= 4'h0;
                drive_q <= 1'b0;
            end else if (i2c_stop) begin
                st_q    <= S_IDLE;
                drive_q <= 1'b0;
            end else begin
                case (st_q)
                    S_ADDR, S_RECV: begin
                        if (scl_rise & (bit_q != `BYTE_BITS)) begin
                            sh_q  <= sh_next;
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall & (bit_q == `BYTE_BITS)) begin
                            bit_q <= 4'h0;
                            if (st_q == S_RECV) begin
                                drive_q <= 1'b1;
                                st_q    <= S_AACK;
                            end else if (addr_hit | gc_hit) begin
                                // 10-bit headers never match 1001xxx
                                drive_q <= 1'b1;
                                dir_q   <= sh_q[0] & ~gc_hit;
                                gcall_q <= gc_hit;
                                byte_q  <= 2'h0;
                                st_q    <= S_AACK;
                            end else begin
                                st_q <= S_IDLE;
                            end
                        end
                    end
                    S_AACK: begin
                        if (scl_rise) begin
                            if (gcall_q & ack_ok_q &
                                (sh_q == `GCALL_RESET))
                                i2c_rst <= 1'b1;
                            if (dir_q & (bit_q == 4'h0))
                                i2c_rd <= 1'b1;
                            bit_q <= 4'h0;
                        end else if (scl_fall) begin
                            drive_q <= 1'b0;
                            if (dir_q) begin
                                drive_q <= ~tx_q[15];
                                sh_q    <= tx_q[15:8];
                                bit_q   <= 4'h1;
                                byte_q  <= 2'h1;
                                st_q    <= S_SEND;
                            end else begin
                                st_q <= S_RECV;
                                if (ack_ok_q & ~gcall_q) begin
                                    if (byte_q == 2'h0)
                                        cmd_q <= sh_q[6:0];
                                    else if (byte_q == 2'h1)
                                        msb_q <= sh_q;
                                    else
                                        i2c_wr <= 1'b1;
                                    byte_q <= (byte_q == 2'h2) ? 2'h1 :
                                              byte_q + 2'h1;
                                end
                            end
                        end
                    end
                    S_SEND: begin
                        if (scl_fall) begin
                            if (bit_q == `BYTE_BITS) begin
                                drive_q <= 1'b0;
                                st_q    <= S_RACK;
                            end else begin
                                drive_q <= ~sh_q[6];
                                sh_q    <= {sh_q[6:0], 1'b0};
                                bit_q   <= bit_q + 4'h1;
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            // controller not-acknowledge ends the read
                            if (sda_s)
                                st_q <= S_IDLE;
                        end else if (scl_fall) begin
                            sh_q    <= (byte_q == 2'h1) ? tx_q[7:0] : 8'h00;
                            drive_q <= (byte_q == 2'h1) ? ~tx_q[7] : 1'b1;
                            byte_q  <= 2'h2;
                            bit_q   <= 4'h1;
                            st_q    <= S_SEND;
                        end
                    end
                    default: begin
                        st_q    <= S_IDLE;
                        drive_q <= 1'b0;
                    end
                endcase
            end
            // set once the address byte is acked
            if (i2c_start)
                ack_ok_q <= 1'b0;
            else if ((st_q == S_AACK) & scl_fall)
                ack_ok_q <= 1'b1;
        end
    end

    // same bit-level machine serves every bus speed
    assign sda_o  = 1'b0;
    assign sda_oe = drive_q;

    // ------------------------------------------------------------
    // register port and lock
    // ------------------------------------------------------------
    reg        wr_q;
    reg        rd_q;
    reg [6:0]  addr_q;
    reg [15:0] wdata_q;
    reg        rst_q;

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_q         <= 1'b0;
            rd_q         <= 1'b0;
            addr_q       <= 7'h00;
            wdata_q      <= 16'h0000;
            rst_q        <= 1'b0;
            iface_q      <= `IFACE_NONE;
            hdr_q        <= 8'h00;
            rd_src_spi_q <= 1'b0;
            rd_pend_q    <= 1'b0;
        end else if (clk_en) begin
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            rst_q     <= i2c_rst;
            rd_pend_q <= rd_q;
            if (spi_go) begin
                iface_q <= `IFACE_SPI;
                addr_q  <= spi_word[`ADDR_MSB:`ADDR_LSB];
                if (spi_read) begin
                    // a read without the readout pin is dropped
                    rd_q         <= readout_pin_enable;
                    rd_src_spi_q <= 1'b1;
                    hdr_q        <= spi_word[`RW_BIT:`ADDR_LSB];
                end else begin
                    wr_q    <= 1'b1;
                    wdata_q <= spi_word[`DATA_MSB:0];
                end
            end else if (i2c_wr | i2c_rd) begin
                iface_q      <= `IFACE_I2C;
                addr_q       <= cmd_q;
                wr_q         <= i2c_wr;
                rd_q         <= i2c_rd;
                rd_src_spi_q <= 1'b0;
                wdata_q      <= {msb_q, sh_q};
            end else if ((st_q == S_AACK) & i2c_allow) begin
                iface_q <= `IFACE_I2C;
            end
        end
    end

    assign reg_wr     = wr_q;
    assign reg_rd     = rd_q;
    assign reg_addr   = addr_q;
    assign reg_wdata  = wdata_q;
    assign soft_reset = rst_q;
    assign iface_type = iface_q;
endmodule

//--- host_if_consts.vh
// constants for the dual serial host interface
`ifndef HOST_IF_CONSTS_VH
`define HOST_IF_CONSTS_VH

// ----------------------------------------------------------------
// spi frame layout
// ----------------------------------------------------------------
`define FRAME_BITS      24
`define FRAME_LAST      5'h17
`define RW_BIT          23
`define ADDR_MSB        22
`define ADDR_LSB        16
`define DATA_MSB        15

// ----------------------------------------------------------------
// i2c addressing
// ----------------------------------------------------------------
`define TARGET_ADDR_HI  4'h9
`define GCALL_ADDR      8'h00
`define GCALL_RESET     8'h06
`define BYTE_BITS       4'h8

// ----------------------------------------------------------------
// locked interface type
// ----------------------------------------------------------------
`define IFACE_NONE      2'h0
`define IFACE_SPI       2'h1
`define IFACE_I2C       2'h2

`endif

//--- pin_sync.v
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clock,
    input  wire         reset,
    input  wire         clk_en,
    // pins in, synchronised levels out
    input  wire [W-1:0] pin_in,
    input  wire [W-1:0] idle_val,
    output wire [W-1:0] level_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // ------------------------------------------------------------
    // one synchroniser per bit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            // flops hold pin xnor idle level, reset is idle
            always @(posedge clock or posedge reset) begin
                if (reset) begin
                    meta_q[i] <= 1'b1;
                    sync_q[i] <= 1'b1;
                end else if (clk_en) begin
                    meta_q[i] <= pin_in[i] ^ ~idle_val[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    // undo the idle flip
    assign level_out = sync_q ^ ~idle_val;
endmodule

//--- host_if_monitor.sv
// assertion checker bound to the serial host interface
`timescale 1ns/1ps
module host_if_monitor (
    // clock and reset
    input wire       clock,
    input wire       reset,
    // spi side
    input wire       frame_sel_n,
    input wire       spi_sdo_oe,
    input wire       readout_pin_enable,
    // i2c side
    input wire       sda_o,
    input wire       sda_oe,
    // register map and control
    input wire       reg_wr,
    input wire       reg_rd,
    input wire       soft_reset,
    input wire [1:0] iface_type
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_wr_one_pulse: assert property (reg_wr |=> !reg_wr)
        else $error("long write strobe");
    a_rd_one_pulse: assert property (reg_rd |=> !reg_rd)
        else $error("long read strobe");
    a_wr_rd_apart: assert property (!(reg_wr && reg_rd))
        else $error("read with write");
    a_wr_after_sel: assert property
        (reg_wr |-> frame_sel_n && $past(frame_sel_n, 3))
        else $error("write in open frame");
    a_sdo_hiz_idle: assert property
        (frame_sel_n [*3] |-> !spi_sdo_oe)
        else $error("sdo driven, no select");
    a_sdo_drive_sel: assert property
        ((!frame_sel_n) [*3] ##0 (readout_pin_enable
        && iface_type != 2'h2) |-> spi_sdo_oe)
        else $error("sdo released in frame");
    a_sdo_needs_en: assert property
        (spi_sdo_oe |-> readout_pin_enable)
        else $error("sdo without enable");
    a_lock_holds: assert property
        (iface_type != 2'h0 |=> $stable(iface_type))
        else $error("lock changed");
    a_no_sdo_i2c: assert property
        (iface_type == 2'h2 |-> !spi_sdo_oe)
        else $error("sdo under i2c lock");
    a_no_ack_spi: assert property
        (iface_type == 2'h1 |-> !sda_oe)
        else $error("sda under spi lock");
    a_soft_pulse: assert property
        (soft_reset |-> iface_type == 2'h2 ##1 !soft_reset)
        else $error("bad soft reset");
    a_sda_low_only: assert property (sda_oe |-> !sda_o)
        else $error("sda driven high");
endmodule

bind serial_host_if host_if_monitor mon (
    .clock(clock), .reset(reset), .frame_sel_n(frame_sel_n),
    .spi_sdo_oe(spi_sdo_oe), .readout_pin_enable(readout_pin_enable),
    .sda_o(sda_o), .sda_oe(sda_oe), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .soft_reset(soft_reset), .iface_type(iface_type));

//--- serial_host_model.sv
// spi host and i2c controller driving the interface pins
`timescale 1ns/1ps
module serial_host_model (
    // clock
    input  wire clock,
    // spi pins
    output reg  frame_sel_n,
    output reg  spi_sclk,
    output reg  spi_sdi,
    input  wire spi_sdo,
    // i2c pins, open drain with pull-up
    output reg  scl,
    output reg  sda_pull,
    input  wire sda
);
    initial begin
        frame_sel_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // half link period; sclk idles low
    task hp;
        repeat (4) @(posedge clock);
    endtask

    task spi_xfer(input integer n, input [71:0] tx, output [71:0] rx);
        integer i;
        begin
            rx = 72'h0;
            frame_sel_n <= 1'b0;
            hp;
            for (i = n - 1; i >= 0; i = i - 1) begin
                spi_sdi <= tx[i];
                spi_sclk <= 1'b1;
                hp;
                rx = {rx[70:0], spi_sdo};
                spi_sclk <= 1'b0;
                hp;
            end
            frame_sel_n <= 1'b1;
            spi_sdi <= ~spi_sdi;
            repeat (12) @(posedge clock);
        end
    endtask

    // ------------------------------------------------------------
    // i2c conditions and bits
    // ------------------------------------------------------------
    task i2c_start;
        begin
            sda_pull <= 1'b0;
            hp;
            scl <= 1'b1;
            hp;
            sda_pull <= 1'b1;
            hp;
            scl <= 1'b0;
            hp;
        end
    endtask

    task i2c_stop;
        begin
            sda_pull <= 1'b1;
            hp;
            scl <= 1'b1;
            hp;
            sda_pull <= 1'b0;
            hp;
        end
    endtask

    task i2c_bit(input b, output r);
        begin
            sda_pull <= ~b;
            hp;
            scl <= 1'b1;
            hp;
            r = sda;
            scl <= 1'b0;
            hp;
        end
    endtask

    // ack_in low acknowledges a byte read from the target
    task i2c_byte(input [7:0] tx, input ack_in, output [7:0] rx,
                  output ack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                i2c_bit(tx[i], r);
                rx[i] = r;
            end
            i2c_bit(ack_in, ack);
        end
    endtask
endmodule

//--- tb_top.sv
// self-checking testbench for the serial host interface
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    reg         clock, reset, readout_pin_enable, readout_edge_select;
    reg  [2:0]  address_select_pin;
    wire        frame_sel_n, spi_sclk, spi_sdi, spi_sdo_o, spi_sdo_oe;
    wire        scl, sda_pull, sda_o, sda_oe, reg_wr, reg_rd, soft_reset;
    wire [6:0]  reg_addr;
    wire [15:0] reg_wdata;
    wire [1:0]  iface_type;
    reg  [15:0] mem [0:127];
    wire [15:0] reg_rdata = mem[reg_addr];
    reg         sdo_last;
    wire        sdo_line = spi_sdo_oe ? spi_sdo_o : ~sdo_last;
    wire        sda_line = !((sda_oe && !sda_o) || sda_pull);
    reg  [22:0] exp_q [$];
    reg  [71:0] rx;
    reg  [6:0]  a, b;
    reg  [15:0] d;
    reg  [7:0]  rb, rc;
    reg  [3:0]  nk;
    reg         k0, k1;
    integer     seed, i, fail_count, n_tests, n_rd, n_soft;

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    serial_host_if dut (
        .clock(clock), .reset(reset), .clk_en(1'b1),
        .frame_sel_n(frame_sel_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
        .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .address_select_pin(address_select_pin),
        .readout_pin_enable(readout_pin_enable),
        .readout_edge_select(readout_edge_select),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .soft_reset(soft_reset), .iface_type(iface_type));

    serial_host_model host (
        .clock(clock), .frame_sel_n(frame_sel_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .spi_sdo(sdo_line), .scl(scl),
        .sda_pull(sda_pull), .sda(sda_line));

    // ------------------------------------------------------------
    // checks and register map model
    // ------------------------------------------------------------
    task check(input ok, input string msg);
        begin
            n_tests = n_tests + 1;
            if (ok !== 1'b1) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: %s", $time, msg);
            end
        end
    endtask

    task finish_test;
        begin
            if (fail_count == 0 && n_tests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    always @(posedge clock) begin
        if (spi_sdo_oe)
            sdo_last <= spi_sdo_o;
        if (reg_rd)
            n_rd = n_rd + 1;
        if (soft_reset)
            n_soft = n_soft + 1;
        if (reg_wr) begin
            check(exp_q.size() > 0 && {reg_addr, reg_wdata} === exp_q[0],
                  "register write");
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
            mem[reg_addr] <= reg_wdata;
        end
    end

    // bytes go out from the top, nk bit set per refused byte
    task i2c_seq(input integer n, input [31:0] bv, output [3:0] nv);
        integer k;
        reg [7:0] r;
        reg ak;
        begin
            nv = 4'h0;
            host.i2c_start;
            for (k = n - 1; k >= 0; k = k - 1) begin
                host.i2c_byte(bv[8*k +: 8], 1'b1, r, ak);
                nv[k] = ak;
            end
            host.i2c_stop;
        end
    endtask

    initial begin
        #1000000;
        fail_count = fail_count + 1;
        finish_test;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 99;
        fail_count = 0;
        n_tests = 0;
        n_rd = 0;
        n_soft = 0;
        sdo_last = 1'b0;
        for (i = 0; i < 128; i = i + 1)
            mem[i] = $random(seed);
        readout_pin_enable = 1'b0;
        readout_edge_select = 1'b1;
        address_select_pin = 3'h0;
        reset = 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        a = $random(seed);
        d = $random(seed);
        host.spi_xfer(23, {1'b0, a, d} >> 1, rx);
        exp_q.push_back({a, d});
        host.spi_xfer(24, {1'b0, a, d}, rx);
        check(iface_type === 2'h1, "spi lock");
        d = ~d;
        exp_q.push_back({a, d});
        host.spi_xfer(30, {1'b0, a, d, 6'h2a}, rx);
        host.spi_xfer(24, {1'b1, a, 16'h0}, rx);
        check(n_rd === 0, "read without sdo enabled");
        @(posedge clock) readout_pin_enable <= 1'b1;
        b = ~a;
        host.spi_xfer(24, {1'b1, b, 16'h0}, rx);
        host.spi_xfer(24, {1'b1, b, 16'h0}, rx);
        check(rx[23:0] === {1'b1, b, mem[b]}, "readback");
        check(n_rd === 2, "read strobes");
        readout_edge_select <= 1'b0;
        exp_q.push_back({a, ~d});
        host.spi_xfer(48, {1'b1, b, d, 1'b0, a, ~d}, rx);
        check(rx[47:0] === {1'b1, b, mem[b], 1'b1, b, d}, "chain");
        host.spi_xfer(30, {1'b0, b, d, 6'h15}, rx);
        i2c_seq(1, {4'h9, address_select_pin, 1'b0}, nk);
        check(nk === 4'h1, "i2c while spi locked");
        check(exp_q.size() === 0, "spi writes");
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        address_select_pin <= $random(seed);
        repeat (4) @(posedge clock);
        a = $random(seed);
        d = $random(seed);
        exp_q.push_back({a, d});
        i2c_seq(4, {4'h9, address_select_pin, 1'b0, 1'b0, a, d}, nk);
        check(nk === 4'h0, "i2c write acks");
        check(iface_type === 2'h2, "i2c lock");
        i2c_seq(4, {4'h9, ~address_select_pin, 1'b0, 24'h0}, nk);
        check(nk === 4'hf, "wrong address");
        i2c_seq(2, {5'h1e, 3'h0, 8'h0}, nk);
        check(nk === 4'h3, "ten-bit header");
        host.i2c_byte({4'h9, address_select_pin, 1'b0}, 1'b1, rb, k0);
        check(k0 === 1'b1, "byte without start");
        host.i2c_start;
        host.i2c_byte({4'h9, address_select_pin, 1'b0}, 1'b1, rb, k0);
        host.i2c_byte({1'b0, a}, 1'b1, rb, k1);
        host.i2c_start;
        host.i2c_byte({4'h9, address_select_pin, 1'b1}, 1'b1, rb, k1);
        host.i2c_byte(8'hff, 1'b0, rb, k0);
        host.i2c_byte(8'hff, 1'b1, rc, k0);
        host.i2c_stop;
        check({rb, rc} === mem[a], "i2c read");
        i2c_seq(2, {16'h0006}, nk);
        check(nk === 4'h0 && n_soft === 1, "general call");
        host.spi_xfer(24, {1'b0, a, d}, rx);
        check(exp_q.size() === 0, "spi while i2c locked");
        finish_test;
    end
endmodule
